// >>> src/rsds_defines.vh
`ifndef RSDS_DEFINES_VH
`define RSDS_DEFINES_VH

// ****************************************
// Register word indexes
// ****************************************
`define RSDS_OFS_CTRL      6'h00
`define RSDS_OFS_CAUSE     6'h01
`define RSDS_OFS_SECOND    6'h02
`define RSDS_OFS_TH_TX1    6'h03
`define RSDS_OFS_TH_RX0    6'h04

// ****************************************
// Control fields and reset values
// ****************************************
`define RSDS_CTRL_RX_LOSS_EN   0
`define RSDS_CTRL_DEM_LOSS_EN  1
`define RSDS_CTRL_AUTO_TX_POWER_CONTROL         2
`define RSDS_CTRL_AIS_DETECT   3
`define RSDS_CTRL_ADAPT_MODE   4
`define RSDS_CTRL_W            5
`define RSDS_CTRL_RESET        5'h07
`define RSDS_TH_RESET          8'h00

// ****************************************
// Synchronised input bit positions
// ****************************************
`define RSDS_IN_RX_LOSS    0
`define RSDS_IN_RX_FAIL    1
`define RSDS_IN_DEM_FAIL   2
`define RSDS_IN_DEM_LOSS   3
`define RSDS_IN_MOD_FAIL   4
`define RSDS_IN_MOD_LOSS   5
`define RSDS_IN_TX_FAIL    6
`define RSDS_IN_TX_LOSS    7
`define RSDS_IN_PLM        8
`define RSDS_IN_LOA        9
`define RSDS_IN_AIS        10
`define RSDS_IN_TIM        11
`define RSDS_IN_SSF        12
`define RSDS_IN_MON        13
`define RSDS_IN_W          14

// ****************************************
// Timing
// ****************************************
`define RSDS_CLK_MHZ         125
`define RSDS_SECOND_MS       1000
`define RSDS_SECOND_CYCLES   (`RSDS_SECOND_MS * 1000 * `RSDS_CLK_MHZ)

`endif

// >>> src/rsds_top.v
// What this block does
// - Receive signal loss defect raised on loss of receiver input signal.
// - If receive loss not distinguishable, report it as receiver failure instead.
// - Demodulation failure defect raised on internal demodulator failure.
// - Demod loss optional; folded into demod failure when not distinguishable.
// - All-ones pattern replaces received data while all-ones insertion is requested.
// - Adaptation sink requests all-ones on payload mismatch, alignment loss, all-ones.
// - Termination sink requests all-ones on all-ones, signal loss, trace mismatch, failure.
// - Insertion starts and stops within two frames of request change.
// - Trail signal fail is OR of all-ones/server fail, loss, mismatch, failure.
// - Trail signal fail goes to adaptation, trail protection and SNC protection.
// - Fault causes follow their expressions directly, never latched.
// - Sink receive loss, receiver fail, demod fail causes gated by monitoring.
// - Demod loss cause when monitoring, demod loss, and no demod failure.
// - Source modulation and transmit causes correlated and gated by monitoring.
// - Flag each second where received level fell below each threshold.
// - With power control, flag each second where transmit level exceeded threshold.
// - Modulation loss defect raised on loss of modulator input data.
// - Transmit failure defect raised on internal transmitter failure.
// - Receiver failure defect raised when no receiver yields a usable signal.
//
// Chosen here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "rsds_defines.vh"

module rsds_top #(
  parameter        NUM_RL        = 2,
  parameter        LEVEL_W       = 8,
  parameter        DATA_W        = 8,
  parameter [31:0] SECOND_CYCLES = `RSDS_SECOND_CYCLES
) (
  // Clock and reset
  input  wire                 clk,
  input  wire                 arst_n,
  // AHB-Lite slave
  input  wire                 hsel,
  input  wire [31:0]          haddr,
  input  wire [1:0]           htrans,
  input  wire                 hwrite,
  input  wire [2:0]           hsize,
  input  wire [31:0]          hwdata,
  input  wire                 hready,
  output wire                 hreadyout,
  output wire                 hresp,
  output reg  [31:0]          hrdata,
  // Raw defects from detectors
  input  wire                 rx_signal_loss_defect,
  input  wire                 receiver_fail_defect,
  input  wire                 demod_fail_defect,
  input  wire                 demod_signal_loss_defect,
  input  wire                 mod_fail_defect,
  input  wire                 mod_signal_loss_defect,
  input  wire                 tx_fail_defect,
  input  wire                 tx_signal_loss_defect,
  input  wire                 payload_mismatch_defect,
  input  wire                 alignment_loss_defect,
  input  wire                 all_ones_detect_defect,
  input  wire                 trace_mismatch_defect,
  input  wire                 server_signal_fail_action,
  input  wire                 monitoring_active,
  // Received data path
  input  wire                 frame_start,
  input  wire [DATA_W-1:0]    rx_data_in,
  output reg  [DATA_W-1:0]    rx_data_out,
  output reg                  all_ones_active,
  // Levels
  input  wire [LEVEL_W-1:0]   received_level,
  input  wire [LEVEL_W-1:0]   transmitted_level,
  // Consequent actions
  output reg                  all_ones_insert_request,
  output reg                  tsf_to_adaptation,
  output reg                  tsf_to_protection,
  output reg                  tsf_to_snc,
  // Fault causes
  output reg                  rx_signal_loss_cause,
  output reg                  receiver_fail_cause,
  output reg                  demod_signal_loss_cause,
  output reg                  demod_fail_cause,
  output reg                  mod_fail_cause,
  output reg                  mod_signal_loss_cause,
  output reg                  tx_fail_cause,
  output reg                  tx_signal_loss_cause,
  // Per-second events
  output reg  [NUM_RL-1:0]    received_level_threshold_second,
  output reg                  transmitted_level_threshold_second
);

  // ****************************************
  // Input synchroniser
  // ****************************************
  // Defect inputs are levels from other clock domains;
  // a pulse shorter than one clock may be lost here
  // Every input reaches the causes three edges after it moves
  // Same-clock inputs (frame start, data, levels) skip this stage
  wire [`RSDS_IN_W-1:0] raw_in;
  reg  [`RSDS_IN_W-1:0] sync_a;
  reg  [`RSDS_IN_W-1:0] sync_b;

  assign raw_in = {monitoring_active, server_signal_fail_action, trace_mismatch_defect,
                   all_ones_detect_defect, alignment_loss_defect, payload_mismatch_defect,
                   tx_signal_loss_defect, tx_fail_defect, mod_signal_loss_defect,
                   mod_fail_defect, demod_signal_loss_defect, demod_fail_defect,
                   receiver_fail_defect, rx_signal_loss_defect};

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_a <= {`RSDS_IN_W{1'b0}};
      sync_b <= {`RSDS_IN_W{1'b0}};
    end else begin
      sync_a <= raw_in;
      sync_b <= sync_a;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  // Word map, byte address four times the index
  //   0 control, read and write:
  //     [0] receive loss told apart from receiver failure
  //     [1] demodulator loss told apart from demodulator failure
  //     [2] transmit power control present
  //     [3] trail signal fail uses all-ones detection, else server fail used
  //     [4] adaptation sink form of the all-ones request
  //   1 causes, read only: [7:0] fault causes, [8] all-ones request,
  //     [9] insertion in force, [10] trail signal fail
  //   2 seconds, read only: [NUM_RL-1:0] receive events, [16] transmit event
  //   3 transmit threshold, read and write
  //   4 and up, one receive threshold each, read and write
  // Anything else reads zero and ignores writes

  reg  [`RSDS_CTRL_W-1:0] ctrl;
  reg  [LEVEL_W-1:0]      th_tx1;
  reg  [LEVEL_W-1:0]      th_rx [0:NUM_RL-1];
  reg  [NUM_RL-1:0]       last_rx_second;
  reg                     last_tx_second;
  reg                     wr_pend;
  reg  [5:0]              wr_idx;
  reg  [31:0]             next_rdata;
  wire                    addr_phase;
  wire [5:0]              rd_idx;
  integer                 i;
  integer                 j;

  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign addr_phase = hsel & htrans[1] & hready;
  assign rd_idx     = haddr[7:2];

  // Unmapped addresses read zero and ignore writes
  always @* begin
    next_rdata = 32'h0000_0000;
    if (rd_idx == `RSDS_OFS_CTRL) begin
      next_rdata[`RSDS_CTRL_W-1:0] = ctrl;
    end else if (rd_idx == `RSDS_OFS_CAUSE) begin
      next_rdata[7:0] = {tx_signal_loss_cause, tx_fail_cause, mod_signal_loss_cause,
                         mod_fail_cause, demod_fail_cause, demod_signal_loss_cause,
                         receiver_fail_cause, rx_signal_loss_cause};
      next_rdata[8]   = all_ones_insert_request;
      next_rdata[9]   = all_ones_active;
      next_rdata[10]  = tsf_to_adaptation;
    end else if (rd_idx == `RSDS_OFS_SECOND) begin
      next_rdata[NUM_RL-1:0] = last_rx_second;
      next_rdata[16]         = last_tx_second;
    end else if (rd_idx == `RSDS_OFS_TH_TX1) begin
      next_rdata[LEVEL_W-1:0] = th_tx1;
    end else begin
      for (i = 0; i < NUM_RL; i = i + 1) begin
        if (rd_idx == `RSDS_OFS_TH_RX0 + i[5:0]) begin
          next_rdata[LEVEL_W-1:0] = th_rx[i];
        end
      end
    end
  end

  // Zero wait states: read data is caught in the address phase, so a read
  // right behind a write to the same word returns the old value
  // Writes land at the end of the data phase
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_pend <= 1'b0;
      wr_idx  <= 6'h00;
      hrdata  <= 32'h0000_0000;
    end else begin
      if (hready) begin
        wr_pend <= addr_phase & hwrite;
        wr_idx  <= rd_idx;
      end
      if (addr_phase & ~hwrite) begin
        hrdata <= next_rdata;
      end
    end
  end

  // Control word and thresholds programmed by management
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl   <= `RSDS_CTRL_RESET;
      th_tx1 <= `RSDS_TH_RESET;
      for (j = 0; j < NUM_RL; j = j + 1) begin
        th_rx[j] <= `RSDS_TH_RESET;
      end
    end else if (wr_pend) begin
      if (wr_idx == `RSDS_OFS_CTRL) begin
        ctrl <= hwdata[`RSDS_CTRL_W-1:0];
      end else if (wr_idx == `RSDS_OFS_TH_TX1) begin
        th_tx1 <= hwdata[LEVEL_W-1:0];
      end else begin
        for (j = 0; j < NUM_RL; j = j + 1) begin
          if (wr_idx == `RSDS_OFS_TH_RX0 + j[5:0]) begin
            th_rx[j] <= hwdata[LEVEL_W-1:0];
          end
        end
      end
    end
  end

  // ****************************************
  // Defect shaping
  // ****************************************
  wire mon      = sync_b[`RSDS_IN_MON];
  wire rx_loss  = sync_b[`RSDS_IN_RX_LOSS] & ctrl[`RSDS_CTRL_RX_LOSS_EN];
  // Loss that cannot be told apart is counted as failure
  wire rx_fail  = sync_b[`RSDS_IN_RX_FAIL] |
                  (sync_b[`RSDS_IN_RX_LOSS] & ~ctrl[`RSDS_CTRL_RX_LOSS_EN]);
  wire dem_loss = sync_b[`RSDS_IN_DEM_LOSS] & ctrl[`RSDS_CTRL_DEM_LOSS_EN];
  wire dem_fail = sync_b[`RSDS_IN_DEM_FAIL] |
                  (sync_b[`RSDS_IN_DEM_LOSS] & ~ctrl[`RSDS_CTRL_DEM_LOSS_EN]);
  wire mod_fail = sync_b[`RSDS_IN_MOD_FAIL];
  wire mod_loss = sync_b[`RSDS_IN_MOD_LOSS];
  wire tx_fail  = sync_b[`RSDS_IN_TX_FAIL];
  wire tx_loss  = sync_b[`RSDS_IN_TX_LOSS];
  wire sig_loss = rx_loss | dem_loss;
  wire rx_f     = rx_fail | dem_fail;
  wire ais_term = ctrl[`RSDS_CTRL_AIS_DETECT] ? sync_b[`RSDS_IN_AIS] : sync_b[`RSDS_IN_SSF];
  wire tsf      = ais_term | sig_loss | sync_b[`RSDS_IN_TIM] | rx_f;
  // The request always uses all-ones detection; only the trail
  // signal fail takes the server fail term in its place
  wire req_term = sync_b[`RSDS_IN_AIS] | sig_loss | sync_b[`RSDS_IN_TIM] | rx_f;
  wire req_adap = sync_b[`RSDS_IN_PLM] | sync_b[`RSDS_IN_LOA] | sync_b[`RSDS_IN_AIS];

  // ****************************************
  // Causes and consequent actions
  // ****************************************
  // Recomputed every cycle, no hold state
  // No persistency filter: a flickering defect makes the cause flicker
  // Receiver-side causes mask the demodulator failure cause behind them
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_signal_loss_cause    <= 1'b0;
      receiver_fail_cause     <= 1'b0;
      demod_signal_loss_cause <= 1'b0;
      demod_fail_cause        <= 1'b0;
      mod_fail_cause          <= 1'b0;
      mod_signal_loss_cause   <= 1'b0;
      tx_fail_cause           <= 1'b0;
      tx_signal_loss_cause    <= 1'b0;
      all_ones_insert_request <= 1'b0;
      tsf_to_adaptation       <= 1'b0;
      tsf_to_protection       <= 1'b0;
      tsf_to_snc              <= 1'b0;
    end else begin
      rx_signal_loss_cause    <= mon & rx_loss & ~rx_fail;
      receiver_fail_cause     <= mon & rx_fail;
      demod_fail_cause        <= mon & dem_fail & ~(rx_loss | rx_fail);
      demod_signal_loss_cause <= mon & dem_loss & ~dem_fail;
      mod_fail_cause          <= mon & mod_fail;
      tx_fail_cause           <= mon & tx_fail & ~mod_fail;
      mod_signal_loss_cause   <= mon & mod_loss & ~mod_fail;
      tx_signal_loss_cause    <= mon & tx_loss & ~(tx_fail | mod_fail);
      all_ones_insert_request <= ctrl[`RSDS_CTRL_ADAPT_MODE] ? req_adap : req_term;
      tsf_to_adaptation       <= tsf;
      tsf_to_protection       <= tsf;
      tsf_to_snc              <= tsf;
    end
  end

  // ****************************************
  // All-ones insertion
  // ****************************************
  // Switching only at frame start keeps frames whole; worst case one frame late
  // Insertion lags the request by at most one frame plus one clock
  // Data output is registered, so it trails rx_data_in by one clock
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      all_ones_active <= 1'b0;
      rx_data_out     <= {DATA_W{1'b0}};
    end else begin
      if (frame_start) begin
        all_ones_active <= all_ones_insert_request;
      end
      rx_data_out <= all_ones_active ? {DATA_W{1'b1}} : rx_data_in;
    end
  end

  // ****************************************
  // Second windows
  // ****************************************
  reg  [31:0]       sec_cnt;
  reg  [NUM_RL-1:0] rx_seen;
  reg               tx_seen;
  wire              sec_tick = (sec_cnt == SECOND_CYCLES - 32'h1);
  wire [NUM_RL-1:0] rx_below;
  wire              tx_above = ctrl[`RSDS_CTRL_AUTO_TX_POWER_CONTROL] & (transmitted_level > th_tx1);

  genvar g;
  generate
    for (g = 0; g < NUM_RL; g = g + 1) begin : g_rx
      assign rx_below[g] = (received_level < th_rx[g]);
    end
  endgenerate

  // Windows run free from reset release and are not tied to any
  // wall-clock second; the register keeps the last finished window
  // until the next one ends, the pulse outputs last one clock
  // A violation in the tick cycle still counts toward the ending window
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sec_cnt                            <= 32'h0000_0000;
      rx_seen                            <= {NUM_RL{1'b0}};
      tx_seen                            <= 1'b0;
      received_level_threshold_second    <= {NUM_RL{1'b0}};
      transmitted_level_threshold_second <= 1'b0;
      last_rx_second                     <= {NUM_RL{1'b0}};
      last_tx_second                     <= 1'b0;
    end else begin
      sec_cnt <= sec_tick ? 32'h0000_0000 : sec_cnt + 32'h1;
      if (sec_tick) begin
        rx_seen                            <= {NUM_RL{1'b0}};
        tx_seen                            <= 1'b0;
        received_level_threshold_second    <= rx_seen | rx_below;
        transmitted_level_threshold_second <= tx_seen | tx_above;
        last_rx_second                     <= rx_seen | rx_below;
        last_tx_second                     <= tx_seen | tx_above;
      end else begin
        rx_seen                            <= rx_seen | rx_below;
        tx_seen                            <= tx_seen | tx_above;
        received_level_threshold_second    <= {NUM_RL{1'b0}};
        transmitted_level_threshold_second <= 1'b0;
      end
    end
  end

endmodule

// >>> tb/rsds_chk.sv
`timescale 1ns/1ps
module rsds_chk #(
  parameter NUM_RL = 2,
  parameter DATA_W = 8
) (
  // Clock and reset
  input wire              clk,
  input wire              arst_n,
  // Inputs watched
  input wire              monitoring_active,
  input wire              frame_start,
  input wire [DATA_W-1:0] rx_data_in,
  // Outputs watched
  input wire [DATA_W-1:0] rx_data_out,
  input wire              all_ones_active,
  input wire              all_ones_insert_request,
  input wire              tsf_to_adaptation,
  input wire              tsf_to_protection,
  input wire              tsf_to_snc,
  input wire              rx_signal_loss_cause,
  input wire              receiver_fail_cause,
  input wire              demod_signal_loss_cause,
  input wire              demod_fail_cause,
  input wire              mod_fail_cause,
  input wire              mod_signal_loss_cause,
  input wire              tx_fail_cause,
  input wire              tx_signal_loss_cause,
  input wire [NUM_RL-1:0] received_level_threshold_second,
  input wire              transmitted_level_threshold_second
);
  wire      sink_any = rx_signal_loss_cause | receiver_fail_cause | demod_signal_loss_cause | demod_fail_cause;
  wire      src_any  = mod_fail_cause | mod_signal_loss_cause | tx_fail_cause | tx_signal_loss_cause;
  wire      sec_any  = (|received_level_threshold_second) | transmitted_level_threshold_second;
  reg       prev_req;
  reg [1:0] frames;

  // ****************************************
  // Frame edges seen since the request moved
  // ****************************************
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_req <= 1'b0;
      frames   <= 2'h0;
    end else begin
      prev_req <= all_ones_insert_request;
      if (all_ones_insert_request != prev_req)
        frames <= 2'h0;
      else if (frame_start && frames != 2'h3)
        frames <= frames + 2'h1;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // Window of three samples tolerates one edge of sync skew
  property p_mon_off; !$past(monitoring_active, 2) && !$past(monitoring_active, 3) && !$past(monitoring_active, 4)
    |-> !(sink_any | src_any); endproperty
  a_mon_off: assert property (p_mon_off) else $error("cause set with monitoring off");
  property p_sink_excl; (rx_signal_loss_cause |-> !(receiver_fail_cause | demod_fail_cause))
    and (demod_signal_loss_cause |-> !demod_fail_cause); endproperty
  a_sink_excl: assert property (p_sink_excl) else $error("sink causes not exclusive");
  property p_src_excl; (mod_fail_cause |-> !(mod_signal_loss_cause | tx_fail_cause | tx_signal_loss_cause))
    and (tx_fail_cause |-> !tx_signal_loss_cause); endproperty
  a_src_excl: assert property (p_src_excl) else $error("source causes not exclusive");
  property p_tsf_eq; tsf_to_protection == tsf_to_adaptation && tsf_to_snc == tsf_to_adaptation; endproperty
  a_tsf_eq: assert property (p_tsf_eq) else $error("trail fail copies differ");
  property p_tsf_cause; sink_any |-> tsf_to_adaptation; endproperty
  a_tsf_cause: assert property (p_tsf_cause) else $error("sink cause without trail fail");
  property p_aones; frames[1] && all_ones_insert_request == prev_req |-> all_ones_active == prev_req; endproperty
  a_aones: assert property (p_aones) else $error("insertion late");
  property p_subst; ($past(all_ones_active) |-> rx_data_out == {DATA_W{1'b1}})
    and (!$past(all_ones_active) |-> rx_data_out == $past(rx_data_in)); endproperty
  a_subst: assert property (p_subst) else $error("received data path wrong");
  property p_pulse; sec_any |=> !sec_any; endproperty
  a_pulse: assert property (p_pulse) else $error("second event wider than one cycle");

  c_mod: cover property ($rose(mod_fail_cause));
  c_ones: cover property ($rose(all_ones_active));
  c_sec: cover property (received_level_threshold_second[1]);
endmodule

bind rsds_top rsds_chk #(.NUM_RL(NUM_RL), .DATA_W(DATA_W)) u_chk (.*);

// >>> tb/rsds_far_end.sv
`timescale 1ns/1ps
module rsds_far_end #(
  parameter FRAME = 8
) (
  // Clock and reset
  input  wire        clk,
  input  wire        arst_n,
  // Defect levels asked for by the bench
  input  wire [13:0] cmd,
  output reg  [13:0] dfx,
  // Received stream
  output reg         frame_start,
  output reg  [7:0]  rx_data_in
);
  reg [7:0] cnt;

  // ****************************************
  // Detectors and framer
  // ****************************************
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dfx         <= 14'h0;
      cnt         <= 8'h00;
      frame_start <= 1'b0;
      rx_data_in  <= 8'h00;
    end else begin
      dfx         <= cmd;
      cnt         <= (cnt == FRAME - 1) ? 8'h00 : cnt + 8'h01;
      frame_start <= (cnt == FRAME - 1);
      rx_data_in  <= rx_data_in + 8'h35;
    end
  end
endmodule

// >>> tb/rsds_top_tb.sv
`timescale 1ns/1ps
`include "rsds_defines.vh"
module rsds_top_tb;
  localparam SEC = 64;
  logic        clk = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, e, p;
  logic [7:0]  received_level = 8'h00, transmitted_level = 8'h00;
  logic [13:0] cmd = 14'h0;
  logic [4:0]  ctrl = 5'h07;
  logic [7:0]  rlv [6] = '{8'h3f, 8'h40, 8'h1f, 8'h20, 8'h00, 8'hff};
  logic [7:0]  tlv [6] = '{8'h81, 8'h80, 8'hff, 8'h00, 8'h7f, 8'hff};
  logic [5:0]  regs [5] = '{`RSDS_OFS_CTRL, `RSDS_OFS_TH_TX1, `RSDS_OFS_TH_RX0, 6'h20, `RSDS_OFS_CAUSE};
  wire  [13:0] dfx;
  wire  [31:0] hrdata;
  wire  [7:0]  rx_data_in, rx_data_out;
  wire  [1:0]  received_level_threshold_second;
  wire hready, hreadyout, hresp, frame_start, all_ones_active, all_ones_insert_request, tsf_to_adaptation;
  wire tsf_to_protection, tsf_to_snc, transmitted_level_threshold_second, rx_signal_loss_cause;
  wire receiver_fail_cause, demod_signal_loss_cause, demod_fail_cause, mod_fail_cause, mod_signal_loss_cause;
  wire tx_fail_cause, tx_signal_loss_cause, rx_signal_loss_defect, receiver_fail_defect, demod_fail_defect;
  wire demod_signal_loss_defect, mod_fail_defect, mod_signal_loss_defect, tx_fail_defect, tx_signal_loss_defect;
  wire payload_mismatch_defect, alignment_loss_defect, all_ones_detect_defect, trace_mismatch_defect;
  wire server_signal_fail_action, monitoring_active;
  int  mismatches = 0, checked = 0;

  assign hready = hreadyout;
  assign {monitoring_active, server_signal_fail_action, trace_mismatch_defect, all_ones_detect_defect,
          alignment_loss_defect, payload_mismatch_defect, tx_signal_loss_defect, tx_fail_defect,
          mod_signal_loss_defect, mod_fail_defect, demod_signal_loss_defect, demod_fail_defect,
          receiver_fail_defect, rx_signal_loss_defect} = dfx;

  rsds_top #(.SECOND_CYCLES(SEC)) dut (.*);
  rsds_far_end #(.FRAME(8)) far (.clk, .arst_n, .cmd, .dfx, .frame_start, .rx_data_in);

  always #4 clk = ~clk;

  // ****************************************
  // Bus, compare and reference model
  // ****************************************
  task wrap_up;
    $display("Counts: %0d checked, %0d mismatches", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask

  task bus(input logic [5:0] idx, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, idx, 2'b00};
    hwrite <= w;
    htrans <= 2'b10;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (hready !== 1'b1 && n < 40);
      if (hready !== 1'b1) begin
        mismatches++;
        wrap_up;
      end
      rd = hrdata;
      chk({31'h0, hresp}, 32'h0);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
    end
  endtask

  // Loss bits fold into failure when ctrl says they cannot be told apart
  function automatic logic [31:0] model(input logic [13:0] d, input logic [4:0] c);
    logic rl, rf, dl, df, los, rxf;
    rl  = c[0] & d[0];
    rf  = d[1] | (~c[0] & d[0]);
    dl  = c[1] & d[3];
    df  = d[2] | (~c[1] & d[3]);
    los = rl | dl;
    rxf = rf | df;
    model = 32'h0;
    model[1:0] = {d[13] & rf, d[13] & rl & ~rf};
    model[3:2] = {d[13] & df & ~(rl | rf), d[13] & dl & ~df};
    model[5:4] = {d[13] & d[5] & ~d[4], d[13] & d[4]};
    model[7:6] = {d[13] & d[7] & ~(d[6] | d[4]), d[13] & d[6] & ~d[4]};
    model[8]   = c[4] ? |d[10:8] : (d[10] | los | d[11] | rxf);
    model[9]   = model[8];
    model[10]  = (c[3] ? d[10] : d[12]) | los | d[11] | rxf;
  endfunction

  initial begin
    e = $urandom(32'h6aa9);
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    bus(6'h20, 1'b1, 32'hffffffff);
    bus(`RSDS_OFS_CAUSE, 1'b1, 32'hffffffff);
    for (int i = 0; i < 5; i++) begin
      bus(regs[i], 1'b0, 32'h0);
      chk(rd, i == 0 ? {27'h0, `RSDS_CTRL_RESET} : 32'h0);
    end
    $display("Test registers done");
    for (int j = 0; j < 3; j++) begin
      ctrl = j == 0 ? 5'h07 : j == 1 ? 5'h18 : 5'h0c;
      bus(`RSDS_OFS_CTRL, 1'b1, {27'h0, ctrl});
      for (int i = 0; i < 28; i++) begin
        @(posedge clk);
        cmd <= {i < 24, 13'($urandom & $urandom)};
        repeat (24) @(posedge clk);
        e = model(cmd, ctrl);
        chk({21'h0, tsf_to_adaptation, all_ones_active, all_ones_insert_request, tx_signal_loss_cause,
             tx_fail_cause, mod_signal_loss_cause, mod_fail_cause, demod_fail_cause, demod_signal_loss_cause,
             receiver_fail_cause, rx_signal_loss_cause}, e);
        chk({30'h0, tsf_to_protection, tsf_to_snc}, {30'h0, e[10], e[10]});
        if (e[8])
          chk({24'h0, rx_data_out}, 32'hff);
        bus(`RSDS_OFS_CAUSE, 1'b0, 32'h0);
        chk(rd, e);
      end
    end
    $display("Test correlation done");
    rlv[4] = 8'($urandom);
    bus(`RSDS_OFS_CTRL, 1'b1, 32'h7);
    bus(`RSDS_OFS_TH_TX1, 1'b1, 32'h80);
    bus(`RSDS_OFS_TH_RX0, 1'b1, 32'h40);
    bus(`RSDS_OFS_TH_RX0 + 6'h1, 1'b1, 32'h20);
    for (int i = 0; i < 7; i++) begin
      ctrl = i == 6 ? 5'h03 : 5'h07;
      bus(`RSDS_OFS_CTRL, 1'b1, {27'h0, ctrl});
      received_level    <= rlv[i % 6];
      transmitted_level <= tlv[i % 6];
      repeat (2 * SEC + 4) @(posedge clk);
      p = 32'h0;
      for (int k = 0; k < SEC; k++) begin
        @(posedge clk);
        p = p | {15'h0, transmitted_level_threshold_second, 14'h0, received_level_threshold_second};
      end
      chk(p, {15'h0, ctrl[2] && tlv[i % 6] > 8'h80, 14'h0, rlv[i % 6] < 8'h20, rlv[i % 6] < 8'h40});
      bus(`RSDS_OFS_SECOND, 1'b0, 32'h0);
      chk(rd, {15'h0, ctrl[2] && tlv[i % 6] > 8'h80, 14'h0, rlv[i % 6] < 8'h20, rlv[i % 6] < 8'h40});
    end
    $display("Test level seconds done");
    wrap_up;
  end
endmodule
